//--- tb/rtc_calendar_alarm_regs_tb.sv
// Purpose: Self-checking bench for the calendar clock core.
// Assumes: One second shortened to 65536 clocks, alarm pulse to 20 clocks.
// Notes: Random user bytes from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module rtc_calendar_alarm_regs_tb;
  import rtc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bkp = 1'b0;
  logic scl, moe, sda_oe, sda_o, pin_o, pin_oe;
  wire sda = ~(moe | sda_oe);
  int miscompares = 0;
  int total_checks = 0;
  always #25 clk = ~clk;
  rtc_core #(.CLK_HZ_P(65536), .TB_HZ_P(32768), .PULSE_CYCLES(20)) dut (.REF_CLK(clk),
    .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE(sda_oe),
    .BACKUP_MODE(bkp), .ALARM_FREQ_PIN_OUT(pin_o), .ALARM_FREQ_PIN_OE(pin_oe));
  rtc_i2c_master m (.clk(clk), .sda(sda), .scl(scl), .sda_oe(moe));
  task automatic stop_test();
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] edges_of(input int code);
    return 8'(64 >> FREQ_BIT[code]);
  endfunction
  task automatic wr(input logic [4:0] a, input logic [7:0] d[$]);
    logic k;
    m.start();
    m.wbyte({DEV_ADDR, 1'b0}, k);
    chk({7'h0, k}, 8'h01);
    m.wbyte({3'h0, a}, k);
    foreach (d[i]) m.wbyte(d[i], k);
    m.stop();
  endtask
  task automatic rd(input logic [4:0] a, input logic cur, input int n, output logic [7:0] q[$]);
    logic k;
    logic [7:0] b;
    q = {};
    m.start();
    if (!cur) begin
      m.wbyte({DEV_ADDR, 1'b0}, k);
      m.wbyte({3'h0, a}, k);
      m.start();
    end
    m.wbyte({DEV_ADDR, 1'b1}, k);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, b);
      q.push_back(b);
    end
    m.stop();
  endtask
  task automatic edges(output logic [7:0] c);
    logic p;
    c = 8'h00;
    p = pin_oe;
    repeat (64) begin
      @(posedge clk);
      #1;
      if (pin_oe !== p) c++;
      p = pin_oe;
    end
  endtask
  initial begin
    repeat (98000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  initial begin
    logic [7:0] q[$];
    logic [7:0] u0, u1, c;
    logic [7:0] t[7];
    logic k;
    int n;
    void'($urandom(32'h57b03294));
    t = '{8'h00, 8'h00, 8'h80, 8'h29, 8'h02, 8'h04, 8'h00};
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    rd(A_STAT, 1'b0, 1, q);
    chk(q[0], STAT_RST);
    wr(A_UNUSED, {8'hff});
    rd(A_UNUSED, 1'b0, 1, q);
    chk(q[0], 8'h00);
    wr(A_SEC, {8'h45});
    rd(A_SEC, 1'b0, 1, q);
    chk(q[0], 8'h00);
    repeat (2) begin
      u0 = 8'($urandom);
      u1 = 8'($urandom);
      wr(A_USR0, {u0, u1});
      rd(A_USR0, 1'b0, 2, q);
      chk(q[0], u0);
      chk(q[1], u1);
      rd(A_USR0, 1'b1, 1, q);
      chk(q[0], u0);
    end
    m.start();
    m.wbyte({~DEV_ADDR, 1'b0}, k);
    m.stop();
    chk({7'h0, k}, 8'h00);
    wr(A_STAT, {8'h80});
    bkp = 1'b1;
    m.start();
    m.wbyte({DEV_ADDR, 1'b0}, k);
    m.stop();
    chk({7'h0, k}, 8'h00);
    bkp = 1'b0;
    rd(A_STAT, 1'b0, 1, q);
    chk(q[0], 8'h83);
    rd(A_STAT, 1'b0, 1, q);
    chk(q[0], 8'h81);
    wr(A_STAT, {8'h10});
    wr(A_ALM0, {8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    wr(A_INTC, {8'hc0});
    wr(A_SEC, {8'h59, 8'h59, 8'ha3, 8'h28, 8'h02, 8'h04, 8'h06});
    n = 0;
    while (pin_oe !== 1'b1 && n < 70000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h0, n > 65000 && n < 65600}, 8'h01);
    n = 0;
    while (pin_oe === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n), 8'd20);
    rd(A_SEC, 1'b0, 7, q);
    for (int i = 0; i < 7; i++) chk(q[i], t[i]);
    rd(A_STAT, 1'b0, 1, q);
    chk(q[0], 8'h14);
    wr(A_INTC, {8'h40});
    chk({7'h0, pin_oe}, 8'h01);
    wr(A_STAT, {8'h10});
    rd(A_STAT, 1'b0, 1, q);
    chk(q[0], 8'h10);
    chk({7'h0, pin_oe}, 8'h00);
    rd(A_DTR, 1'b0, 2, q);
    chk(q[0], 8'h00);
    chk(q[1], 8'h10);
    for (int code = 1; code < 4; code++) begin
      wr(A_INTC, {8'h40 | 8'(code)});
      edges(c);
      chk(c, edges_of(code));
    end
    wr(A_INTC, {8'h11});
    bkp = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    edges(c);
    chk(c, 8'h00);
    bkp = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    wr(A_INTC, {8'h00});
    edges(c);
    chk({c[6:0], pin_oe}, 8'h00);
    chk({6'h0, sda_o, pin_o}, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire

//--- tb/rtc_i2c_master.sv
// Purpose: Two-wire bus master model driving the clock core serial port.
// Assumes: SDA has a pull-up; SCL is driven only by this model.
// Notes: Each phase lasts HP reference clocks; changes land 1 ns after an edge.
`timescale 1ns/1ps
`default_nettype none
module rtc_i2c_master #(
  parameter int HP = 8
) (
  // Reference clock and bus pins
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic hp();
    repeat (HP) @(posedge clk);
    #1;
  endtask
  task automatic start();
    sda_oe = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_oe = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_oe = 1'b0;
    hp();
  endtask
  // Drive one bit while SCL is low, sample the wire before SCL falls
  task automatic bit_io(input logic b, output logic v);
    sda_oe = ~b;
    hp();
    scl = 1'b1;
    hp();
    v = sda;
    scl = 1'b0;
    hp();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) bit_io(d[i], v);
    bit_io(1'b1, v);
    ack = ~v;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v);
      d[i] = v;
    end
    bit_io(~more, v);
  endtask
endmodule
`default_nettype wire

//--- verilog/rtc_core.sv
// Purpose: Calendar clock core with alarm, frequency output and two-wire slave port.
// Assumes: SCL, SDA and the backup indication come from outside and are synchronised.
// Notes: Open-drain pins are split into output and enable; the output level is always low.
// Overview of operation
// R1 - After total power loss counters stay frozen until a clock byte write is closed by STOP.
// R2 - Seconds to year counters roll over, honouring short months and leap years.
// R3 - Alarm works only when alarm_on is set; repeat select picks single or recurring.
// R4 - Any nonzero frequency selection disables the alarm and owns the shared pin.
// R5 - Single mode: matching enabled fields pull the pin low and set alarm_flag.
// R6 - Recurring mode: every match sets alarm_flag and pulls the pin low 250 ms.
// R7 - alarm_flag stays set until host clears it or autoclear does.
// R8 - In backup with pin_off_in_backup set, both pin functions are silenced.
// R9 - Fifteen nonzero output frequencies up to 32 kHz; zero turns output off.
// R10 - Two user bytes are kept through backup operation; the serial port cannot reach them while in backup.
// R11 - In backup the serial port ignores all traffic and never answers.
// R12 - Slave answers address 1101111x and decodes registers 00h to 13h.
// R13 - Register 09h does nothing: writes ignored, reads return zero.
// R14 - Map has clock, control, alarm and user sections; nothing above 13h.
// R15 - Clock registers accept writes only while clock_write_unlock is set.
// R16 - Bursts stay inside one section and may start anywhere in it.
// R17 - A clock or alarm read freezes all clock registers into a holding copy.
// R18 - After a read the pointer stands one past the last register read.
// R19 - Time is held in BCD with the documented ranges and 12 or 24 hour form.
// R20 - Weekday counts 0 to 6 and wraps, stepping at each day rollover.
// R21 - hour_format_24 selects 24 hour form; else pm_indicator marks afternoon.
// R22 - Every year divisible by four is a leap year, with no century exception.
// R23 - A clock write closed by STOP starts counting and realigns the second tick.
// R24 - With flag_autoclear, a status read closed by STOP clears alarm and backup flags.
// R25 - Frequency code 1 gives 32768 Hz, descending through 1/32 Hz at code 15.
// R26 - Single mode holds the pin low until alarm_flag is cleared.
// R27 - Bit 7 of each alarm register enables that field; all enabled fields must match.
`timescale 1ns/1ps
`default_nettype none
module rtc_core #(
  parameter int unsigned CLK_HZ_P = rtc_pkg::CLK_HZ,
  parameter int unsigned TB_HZ_P = rtc_pkg::TB_HZ,
  parameter int unsigned PULSE_CYCLES = rtc_pkg::PULSE_CYC
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Serial port pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Supply state
  input wire logic BACKUP_MODE,
  // Shared alarm and frequency pin
  output logic ALARM_FREQ_PIN_OUT,
  output logic ALARM_FREQ_PIN_OE
);
  import rtc_pkg::*;

  if (TB_HZ_P * 2 > CLK_HZ_P || PULSE_CYCLES < 1) begin : g_chk
    $error("rtc_core: clock too slow for the timebase or pulse length zero");
  end

  logic [2:0] scl_sy, sda_sy;
  logic [1:0] bkp_sy;
  logic bkp_d_ff;
  logic [31:0] acc_ff;
  logic half_tick;
  logic [PRE_W-1:0] pre_ff;
  logic sec_tick, sec_upd_ff;
  logic running_ff;
  logic [7:0] time_ff [7];
  logic [7:0] nxt_time [7];
  logic [7:0] shadow_ff [7];
  logic [7:0] cfg_ff [8:19];
  logic autoclr_ff, xtal_ff, unlock_ff, alarm_flag_ff, backup_flag_ff, ploss_ff;
  logic keep_alm_ff;
  logic [7:0] status;
  logic day_roll;
  logic [7:0] last_day;
  logic leap;
  logic [7:0] hr24_inc, hr12_inc;
  i2c_st_t st_ff;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff, tx_ff, rd_data;
  logic rw_ff, sda_oe_ff;
  logic [4:0] ptr_ff, ptr_nx;
  logic wr_pulse_ff;
  logic [4:0] wr_addr_ff;
  logic [7:0] wr_data_ff;
  logic latch_ff, stat_rd_ff, clk_wr_ff, restart_ff, aclr_ff;
  logic start_c, stop_c, scl_rise, scl_fall;
  logic clk_wr_ok;
  logic [5:0] fld_en, fld_hit;
  logic match, alarm_live, alarm_evt;
  logic [31:0] pulse_cnt_ff;
  logic pin_oe_ff;
  logic [3:0] fsel;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // Pin synchronisers
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
      bkp_sy <= 2'h0;
      bkp_d_ff <= 1'b0;
    end else begin
      scl_sy <= {scl_sy[1:0], SCL_IN};
      sda_sy <= {sda_sy[1:0], SDA_IN};
      bkp_sy <= {bkp_sy[0], BACKUP_MODE};
      bkp_d_ff <= bkp_sy[1];
    end
  end

  assign scl_rise = scl_sy[1] && !scl_sy[2];
  assign scl_fall = !scl_sy[1] && scl_sy[2];
  assign start_c = scl_sy[1] && scl_sy[2] && sda_sy[2] && !sda_sy[1];
  assign stop_c = scl_sy[1] && scl_sy[2] && !sda_sy[2] && sda_sy[1];

  // Timebase at twice the crystal rate, then a binary divider
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      acc_ff <= 32'h0;
    end else if (acc_ff + 2 * TB_HZ_P >= CLK_HZ_P) begin
      acc_ff <= acc_ff + 2 * TB_HZ_P - CLK_HZ_P;
    end else begin
      acc_ff <= acc_ff + 2 * TB_HZ_P;
    end
  end
  assign half_tick = (acc_ff + 2 * TB_HZ_P >= CLK_HZ_P);

  always_ff @(posedge REF_CLK) begin
    if (RST || restart_ff) begin
      pre_ff <= '0; // R23
    end else if (half_tick) begin
      pre_ff <= pre_ff + 1'b1;
    end
  end
  assign sec_tick = half_tick && running_ff && (pre_ff[15:0] == SEC_WRAP); // R1

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      running_ff <= 1'b0;
      sec_upd_ff <= 1'b0;
    end else begin
      sec_upd_ff <= sec_tick;
      if (restart_ff) begin
        running_ff <= 1'b1; // R1 R23
      end
    end
  end

  // Calendar next-state
  assign hr24_inc = bcd_inc({2'b00, time_ff[2][5:0]});
  assign hr12_inc = bcd_inc({3'b000, time_ff[2][4:0]});
  assign leap = time_ff[5][4] ? (time_ff[5][1:0] == 2'h2) : (time_ff[5][1:0] == 2'h0); // R22
  always_comb begin
    case (time_ff[4][4:0])
      5'h02: last_day = leap ? 8'h29 : 8'h28; // R22
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30; // R2
      default: last_day = 8'h31;
    endcase
  end

  always_comb begin
    nxt_time = time_ff;
    day_roll = 1'b0;
    if (time_ff[0][6:0] == 7'h59) begin
      nxt_time[0] = 8'h00; // R19
      if (time_ff[1][6:0] == 7'h59) begin
        nxt_time[1] = 8'h00;
        if (time_ff[2][HR_FMT24]) begin
          if (time_ff[2][5:0] == 6'h23) begin
            nxt_time[2] = 8'h80; // R21
            day_roll = 1'b1;
          end else begin
            nxt_time[2] = {2'b10, hr24_inc[5:0]};
          end
        end else if (time_ff[2][4:0] == 5'h11) begin
          nxt_time[2] = {2'b00, ~time_ff[2][5], 5'h12}; // R21
          day_roll = time_ff[2][5];
        end else if (time_ff[2][4:0] == 5'h12) begin
          nxt_time[2] = {2'b00, time_ff[2][5], 5'h01};
        end else begin
          nxt_time[2] = {2'b00, time_ff[2][5], hr12_inc[4:0]};
        end
      end else begin
        nxt_time[1] = bcd_inc(time_ff[1]);
      end
    end else begin
      nxt_time[0] = bcd_inc(time_ff[0]);
    end
    if (day_roll) begin
      nxt_time[6] = (time_ff[6][2:0] == 3'h6) ? 8'h00 : time_ff[6] + 8'h01; // R20
      if (time_ff[3] >= last_day) begin
        nxt_time[3] = 8'h01; // R2
        if (time_ff[4] >= 8'h12) begin
          nxt_time[4] = 8'h01;
          nxt_time[5] = (time_ff[5] == 8'h99) ? 8'h00 : bcd_inc(time_ff[5]);
        end else begin
          nxt_time[4] = bcd_inc(time_ff[4]);
        end
      end else begin
        nxt_time[3] = bcd_inc(time_ff[3]);
      end
    end
  end

  assign clk_wr_ok = wr_pulse_ff && (wr_addr_ff <= A_WDAY) && unlock_ff;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int i = 0; i < 7; i++) begin
        time_ff[i] <= 8'h00;
      end
    end else if (clk_wr_ok) begin
      time_ff[wr_addr_ff[2:0]] <= wr_data_ff & TIME_MASK[wr_addr_ff[2:0]]; // R15
    end else if (sec_tick) begin
      time_ff <= nxt_time; // R2
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int i = 0; i < 7; i++) begin
        shadow_ff[i] <= 8'h00;
      end
    end else if (latch_ff) begin
      shadow_ff <= time_ff; // R17
    end
  end

  // Control, alarm and user bytes; 09h is never stored
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int i = 8; i < 20; i++) begin
        cfg_ff[i] <= CFG_RST;
      end
    end else if (wr_pulse_ff && wr_addr_ff >= A_INTC && wr_addr_ff <= A_LAST) begin
      if (wr_addr_ff == A_DTR) begin
        cfg_ff[A_DTR] <= wr_data_ff & DTR_MASK;
      end else if (wr_addr_ff != A_UNUSED) begin
        cfg_ff[wr_addr_ff] <= wr_data_ff; // R10 R13
      end
    end
  end
  assign fsel = cfg_ff[A_INTC][3:0];

  // Status flags: hardware set wins over any clear
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      {autoclr_ff, xtal_ff, unlock_ff} <= 3'h0;
      {alarm_flag_ff, backup_flag_ff, keep_alm_ff} <= 3'h0;
      ploss_ff <= STAT_RST[ST_PLOSS];
    end else begin
      if (wr_pulse_ff && wr_addr_ff == A_STAT) begin
        autoclr_ff <= wr_data_ff[ST_AUTOCLR];
        xtal_ff <= wr_data_ff[ST_XTAL];
        unlock_ff <= wr_data_ff[ST_UNLOCK];
      end
      if (clk_wr_ok) begin
        ploss_ff <= 1'b0; // R1
      end
      if (alarm_evt) begin
        alarm_flag_ff <= 1'b1; // R5 R6
      end else if (wr_pulse_ff && wr_addr_ff == A_STAT && !wr_data_ff[ST_ALARM]) begin
        alarm_flag_ff <= 1'b0; // R7
      end else if (aclr_ff && autoclr_ff && !keep_alm_ff) begin
        alarm_flag_ff <= 1'b0; // R24
      end
      if (bkp_sy[1] && !bkp_d_ff) begin
        backup_flag_ff <= 1'b1;
      end else if (wr_pulse_ff && wr_addr_ff == A_STAT && !wr_data_ff[ST_BACKUP]) begin
        backup_flag_ff <= 1'b0;
      end else if (aclr_ff && autoclr_ff) begin
        backup_flag_ff <= 1'b0; // R24
      end
      if (aclr_ff) begin
        keep_alm_ff <= 1'b0;
      end else if (alarm_evt && stat_rd_ff) begin
        keep_alm_ff <= 1'b1;
      end
    end
  end
  assign status = {autoclr_ff, xtal_ff, 1'b0, unlock_ff, 1'b0, alarm_flag_ff, backup_flag_ff,
                   ploss_ff};

  // Read data; the load at the address acknowledge sees live time being latched
  always_comb begin
    rd_data = 8'h00;
    if (ptr_ff <= A_WDAY) begin
      rd_data = (st_ff == S_DEVACK) ? time_ff[ptr_ff[2:0]] : shadow_ff[ptr_ff[2:0]]; // R17
    end else if (ptr_ff == A_STAT) begin
      rd_data = status;
    end else if (ptr_ff <= A_LAST && ptr_ff != A_UNUSED) begin
      rd_data = cfg_ff[ptr_ff]; // R13 R14
    end
  end

  // Pointer step wraps inside the current section
  always_comb begin
    case (ptr_ff)
      A_WDAY: ptr_nx = A_SEC; // R16
      A_DTR: ptr_nx = A_STAT;
      A_ALM_END: ptr_nx = A_ALM0;
      A_LAST: ptr_nx = A_USR0;
      default: ptr_nx = ptr_ff + 5'h01; // R18
    endcase
  end

  // Serial slave
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_ff <= S_IDLE;
      {cnt_ff, sh_ff, tx_ff} <= '0;
      {rw_ff, sda_oe_ff, wr_pulse_ff, latch_ff} <= 4'h0;
      {stat_rd_ff, clk_wr_ff, restart_ff, aclr_ff} <= 4'h0;
      ptr_ff <= A_SEC;
      wr_addr_ff <= A_SEC;
      wr_data_ff <= 8'h00;
    end else if (bkp_sy[1]) begin
      st_ff <= S_IDLE; // R11
      {sda_oe_ff, wr_pulse_ff, latch_ff} <= 3'h0;
      {stat_rd_ff, clk_wr_ff, restart_ff, aclr_ff} <= 4'h0;
    end else begin
      {wr_pulse_ff, latch_ff, restart_ff, aclr_ff} <= 4'h0;
      if (start_c) begin
        st_ff <= S_DEV;
        cnt_ff <= 4'h0;
        sda_oe_ff <= 1'b0;
      end else if (stop_c) begin
        st_ff <= S_IDLE;
        sda_oe_ff <= 1'b0;
        restart_ff <= clk_wr_ff; // R23
        aclr_ff <= stat_rd_ff; // R24
        clk_wr_ff <= 1'b0;
        stat_rd_ff <= 1'b0;
      end else if (scl_rise) begin
        case (st_ff)
          S_DEV, S_PTR, S_WR: begin
            sh_ff <= {sh_ff[6:0], sda_sy[1]};
            cnt_ff <= cnt_ff + 4'h1;
          end
          S_RACK: st_ff <= sda_sy[1] ? S_IDLE : S_RNEXT;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (st_ff)
          S_DEV: if (cnt_ff == 4'h8) begin
            if (sh_ff[7:1] == DEV_ADDR) begin
              st_ff <= S_DEVACK; // R12
              sda_oe_ff <= 1'b1;
              rw_ff <= sh_ff[0];
            end else begin
              st_ff <= S_IDLE;
            end
          end
          S_PTR: if (cnt_ff == 4'h8) begin
            ptr_ff <= sh_ff[4:0];
            sda_oe_ff <= 1'b1;
            st_ff <= S_PTRACK;
          end
          S_WR: if (cnt_ff == 4'h8) begin
            wr_pulse_ff <= 1'b1;
            wr_addr_ff <= ptr_ff;
            wr_data_ff <= sh_ff;
            sda_oe_ff <= 1'b1;
            st_ff <= S_WRACK;
            if (ptr_ff <= A_WDAY && unlock_ff) begin
              clk_wr_ff <= 1'b1;
            end
          end
          S_DEVACK: begin
            cnt_ff <= 4'h0;
            if (rw_ff) begin
              latch_ff <= (ptr_ff <= A_WDAY) || (ptr_ff >= A_ALM0 && ptr_ff <= A_ALM_END); // R17
              tx_ff <= rd_data;
              sda_oe_ff <= !rd_data[7];
              stat_rd_ff <= stat_rd_ff || (ptr_ff == A_STAT);
              st_ff <= S_RD;
            end else begin
              sda_oe_ff <= 1'b0;
              st_ff <= S_PTR;
            end
          end
          S_PTRACK, S_WRACK: begin
            sda_oe_ff <= 1'b0;
            cnt_ff <= 4'h0;
            if (st_ff == S_WRACK) begin
              ptr_ff <= ptr_nx; // R16
            end
            st_ff <= S_WR;
          end
          S_RD: if (cnt_ff == 4'h7) begin
            sda_oe_ff <= 1'b0;
            ptr_ff <= ptr_nx; // R18
            st_ff <= S_RACK;
          end else begin
            tx_ff <= {tx_ff[6:0], 1'b0};
            sda_oe_ff <= !tx_ff[6];
            cnt_ff <= cnt_ff + 4'h1;
          end
          S_RNEXT: begin
            tx_ff <= rd_data;
            sda_oe_ff <= !rd_data[7];
            stat_rd_ff <= stat_rd_ff || (ptr_ff == A_STAT);
            cnt_ff <= 4'h0;
            st_ff <= S_RD;
          end
          default: st_ff <= S_IDLE;
        endcase
      end
    end
  end
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_oe_ff;

  // Alarm compare per field; alarm field 5 is the weekday
  for (genvar i = 0; i < 6; i++) begin : g_fld
    localparam int TI = (i == 5) ? 6 : i;
    assign fld_en[i] = cfg_ff[A_ALM0 + i][ALM_EN]; // R27
    assign fld_hit[i] = !fld_en[i] ||
        ((cfg_ff[A_ALM0 + i][6:0] & TIME_MASK[TI][6:0]) == (time_ff[TI][6:0] & TIME_MASK[TI][6:0]));
  end
  assign match = (|fld_en) && (&fld_hit); // R27
  assign alarm_live = cfg_ff[A_INTC][IC_ALM_ON] && (fsel == 4'h0); // R3 R4
  assign alarm_evt = alarm_live && sec_upd_ff && match;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pulse_cnt_ff <= 32'h0;
    end else if (alarm_evt && cfg_ff[A_INTC][IC_REPEAT]) begin
      pulse_cnt_ff <= PULSE_CYCLES; // R6
    end else if (pulse_cnt_ff != 32'h0) begin
      pulse_cnt_ff <= pulse_cnt_ff - 32'h1;
    end
  end

  // Shared pin: frequency output overrides the alarm
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pin_oe_ff <= 1'b0;
    end else if (bkp_sy[1] && cfg_ff[A_INTC][IC_PIN_OFF]) begin
      pin_oe_ff <= 1'b0; // R8
    end else if (fsel != 4'h0) begin
      pin_oe_ff <= !pre_ff[FREQ_BIT[fsel]]; // R4 R9 R25
    end else if (cfg_ff[A_INTC][IC_REPEAT]) begin
      pin_oe_ff <= alarm_live && (pulse_cnt_ff != 32'h0); // R6
    end else begin
      pin_oe_ff <= alarm_live && alarm_flag_ff; // R5 R26
    end
  end
  assign ALARM_FREQ_PIN_OUT = 1'b0;
  assign ALARM_FREQ_PIN_OE = pin_oe_ff;

  a_frozen_clock: assert property (@(posedge REF_CLK) disable iff (RST) // R1
    (!running_ff && !clk_wr_ok) |=> $stable(time_ff[0])) else $error("time moved while frozen");
  a_unlock_guard: assert property (@(posedge REF_CLK) disable iff (RST) // R15
    (wr_pulse_ff && wr_addr_ff == A_SEC && !unlock_ff && !sec_tick) |=> $stable(time_ff[0]))
    else $error("locked clock write took effect");
  a_freq_blocks_alarm: assert property (@(posedge REF_CLK) disable iff (RST) // R4
    (fsel != 4'h0 && sec_upd_ff && match) |=> !$rose(alarm_flag_ff))
    else $error("alarm fired with frequency output on");
  a_alarm_sets_flag: assert property (@(posedge REF_CLK) disable iff (RST) // R5
    alarm_evt |=> alarm_flag_ff) else $error("alarm event did not set flag");
  a_single_pin_low: assert property (@(posedge REF_CLK) disable iff (RST) // R26
    (alarm_live && !cfg_ff[A_INTC][IC_REPEAT] && alarm_flag_ff && !bkp_sy[1]) ##1
    (alarm_live && !cfg_ff[A_INTC][IC_REPEAT]) |-> ALARM_FREQ_PIN_OE)
    else $error("single alarm pin released while flag set");
  a_pulse_start: assert property (@(posedge REF_CLK) disable iff (RST) // R6
    (alarm_evt && cfg_ff[A_INTC][IC_REPEAT] && !bkp_sy[1]) ##1 (fsel == 4'h0 && !bkp_sy[1] &&
    cfg_ff[A_INTC][IC_REPEAT] && alarm_live) |-> ##1 ALARM_FREQ_PIN_OE)
    else $error("recurring alarm pulse missing");
  a_pin_off_backup: assert property (@(posedge REF_CLK) disable iff (RST) // R8
    (bkp_sy[1] && cfg_ff[A_INTC][IC_PIN_OFF]) |=> !ALARM_FREQ_PIN_OE)
    else $error("shared pin active in backup");
  a_bus_silent: assert property (@(posedge REF_CLK) disable iff (RST) // R11
    bkp_sy[1] |=> !SDA_OE) else $error("serial port answered in backup");
  a_weekday_wrap: assert property (@(posedge REF_CLK) disable iff (RST) // R20
    (sec_tick && !clk_wr_ok && day_roll && time_ff[6] == 8'h06) |=> time_ff[6] == 8'h00)
    else $error("weekday did not wrap");
  a_ptr_advance: assert property (@(posedge REF_CLK) disable iff (RST) // R18
    (!bkp_sy[1] && !start_c && !stop_c && scl_fall && st_ff == S_RD && cnt_ff == 4'h7) |=>
    (ptr_ff == $past(ptr_nx) && st_ff == S_RACK)) else $error("pointer not advanced");
  a_autoclear: assert property (@(posedge REF_CLK) disable iff (RST) // R24
    (aclr_ff && autoclr_ff && !alarm_evt && !keep_alm_ff) |=> !alarm_flag_ff)
    else $error("autoclear missed");
endmodule
`default_nettype wire

//--- verilog/rtc_pkg.sv
// Purpose: Shared constants and types for the calendar clock core.
// Assumes: 20 MHz reference clock; 32.768 kHz timebase made by a fraction accumulator.
// Notes: Register offsets are byte addresses on the serial port.
package rtc_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TB_HZ = 32768;
  localparam int unsigned PULSE_MS = 250;
  localparam int unsigned PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
  localparam logic [6:0] DEV_ADDR = 7'h6f;
  localparam logic [4:0] A_SEC = 5'h00;
  localparam logic [4:0] A_WDAY = 5'h06;
  localparam logic [4:0] A_STAT = 5'h07;
  localparam logic [4:0] A_INTC = 5'h08;
  localparam logic [4:0] A_UNUSED = 5'h09;
  localparam logic [4:0] A_DTR = 5'h0b;
  localparam logic [4:0] A_ALM0 = 5'h0c;
  localparam logic [4:0] A_ALM_END = 5'h11;
  localparam logic [4:0] A_USR0 = 5'h12;
  localparam logic [4:0] A_LAST = 5'h13;
  localparam logic [7:0] TIME_MASK [7] = '{8'h7f, 8'h7f, 8'hbf, 8'h3f, 8'h1f, 8'hff, 8'h07};
  localparam logic [7:0] DTR_MASK = 8'h07;
  localparam logic [7:0] STAT_RST = 8'h01;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int ST_AUTOCLR = 7;
  localparam int ST_XTAL = 6;
  localparam int ST_UNLOCK = 4;
  localparam int ST_ALARM = 2;
  localparam int ST_BACKUP = 1;
  localparam int ST_PLOSS = 0;
  localparam int IC_REPEAT = 7;
  localparam int IC_ALM_ON = 6;
  localparam int IC_PIN_OFF = 4;
  localparam int HR_FMT24 = 7;
  localparam int ALM_EN = 7;
  localparam int PRE_W = 21;
  localparam logic [15:0] SEC_WRAP = 16'hffff;
  // Divider bit giving each selectable output frequency
  localparam logic [4:0] FREQ_BIT [16] = '{5'd0, 5'd0, 5'd3, 5'd5, 5'd9, 5'd10, 5'd11, 5'd12,
                                          5'd13, 5'd14, 5'd15, 5'd16, 5'd17, 5'd18, 5'd19, 5'd20};
  typedef enum {S_IDLE, S_DEV, S_DEVACK, S_PTR, S_PTRACK, S_WR, S_WRACK, S_RD, S_RACK,
                S_RNEXT} i2c_st_t;
endpackage
